/* File: rtl/arbs_pkg.sv */
// Constants for the average-rate baud select block: offsets, fields, resets, codes and rate table.
// Assumes a 32-bit APB with a 24-bit byte address and a single 200 MHz clock.
package arbs_pkg;

	// Bus widths and accumulator width.
	localparam int ADDR_W = 24;
	localparam int DATA_W = 32;
	localparam int ACC_W  = 26;
	localparam int ACS_W  = 4;

	// Register byte addresses.
	localparam logic [23:0] CTRL_OFS  = 24'hfff600;
	localparam logic [23:0] PRESC_OFS = 24'hfff604;
	localparam logic [23:0] SEMR_OFS  = 24'hfff608;
	localparam logic [23:0] STAT_OFS  = 24'hfff60c;

	// Field positions.
	localparam int CTRL_SMART_BIT = 0;
	localparam int CTRL_SYNC_BIT  = 1;
	localparam int CTRL_EXT_BIT   = 2;
	localparam int SEMR_ASYNC_BASE_CLOCK_SELECT_BIT  = 4;

	// Values after reset.
	localparam logic [2:0] CTRL_RST  = 3'h0;
	localparam logic [4:0] SEMR_RST  = 5'h03;
	localparam logic [7:0] PRESC_RST = 8'h0f;

	// Base clock cycles per bit period.
	localparam logic [4:0] BASE_PER_BIT_16 = 5'h10;
	localparam logic [4:0] BASE_PER_BIT_8  = 5'h08;

	// Clock source codes.
	localparam logic [3:0] CODE_NONE = 4'h0;
	localparam logic [3:0] CODE_TMR  = 4'h4;
	localparam logic [3:0] CODE_LAST = 4'hc;

	// Average rates in bit/s and the peripheral clock in Hz each code is calibrated for.
	localparam int unsigned RATE_C1 = 115152;
	localparam int unsigned RATE_C2 = 460606;
	localparam int unsigned RATE_C3 = 921569;
	localparam int unsigned RATE_C5 = 115196;
	localparam int unsigned RATE_C6 = 460784;
	localparam int unsigned RATE_C7 = 720000;
	localparam int unsigned RATE_C8 = 115132;
	localparam int unsigned RATE_C9 = 460526;
	localparam int unsigned RATE_CA = 720000;
	localparam int unsigned RATE_CB = 921053;
	localparam int unsigned RATE_CC = 720000;
	localparam int unsigned PCLK_10M667 = 10667000;
	localparam int unsigned PCLK_16M    = 16000000;
	localparam int unsigned PCLK_24M    = 24000000;
	localparam int unsigned PCLK_32M    = 32000000;

endpackage : arbs_pkg

/* File: rtl/arbs_rate_gen.sv */
// Fractional accumulator that emits base clock ticks at inc/modulus of the clock rate.
// Assumes modulus is above inc and both are steady while clear is low.
`timescale 1ns/1ps
module arbs_rate_gen #(
	parameter int W = arbs_pkg::ACC_W
) (
	// Clock and reset.
	input  wire logic         clk,
	input  wire logic         rst,
	// Ratio and restart.
	input  wire logic         clear,
	input  wire logic [W-1:0] inc,
	input  wire logic [W-1:0] modulus,
	// One-cycle base clock enable.
	output logic              tick
);

	logic [W-1:0] acc_q;   // Running phase.
	logic [W-1:0] acc_d;   // Next phase.
	logic [W:0]   sum;     // Phase plus step, one bit wider.
	logic         wrap;    // Phase passed the modulus.

	// Wrapping keeps the remainder, so the long-term rate is exact even though single periods jitter.
	assign sum   = {1'b0, acc_q} + {1'b0, inc};
	assign wrap  = sum >= {1'b0, modulus};
	assign acc_d = wrap ? W'(sum - {1'b0, modulus}) : W'(sum);

	// Phase register and tick.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acc_q <= '0;
			tick  <= 1'b0;
		end else if (clear) begin
			acc_q <= '0;
			tick  <= 1'b0;
		end else begin
			acc_q <= acc_d;
			tick  <= wrap;
		end
	end

endmodule : arbs_rate_gen

/* File: rtl/arbs_baud_select.sv */
// Clock source and bit-rate selection for one async serial channel, with its APB registers.
// Assumes a same-clock timer match pulse and an external serial clock pin from outside the domain.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
module arbs_baud_select (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [23:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Clock sources.
	input  wire logic        tmr_match,
	input  wire logic        sck_in,
	// Channel side.
	output logic             smart_card_mode,
	output logic             sync_mode,
	output logic             ext_clk_sel,
	output logic             div8_sel,
	output logic             base_tick,
	output logic             bit_tick
);

	// Register state.
	logic [2:0]  ctrl_q;      // Smart card, sync mode, external clock.
	logic [4:0]  semr_q;      // Base select and source field.
	logic [7:0]  presc_q;     // Internal prescaler reload.
	logic [31:0] prdata_q;    // Read data captured in setup.

	// Bus decode.
	wire setup_ph  = psel & ~penable;
	wire access_ph = psel & penable;
	wire hit_ctrl  = paddr == arbs_pkg::CTRL_OFS;
	wire hit_presc = paddr == arbs_pkg::PRESC_OFS;
	wire hit_semr  = paddr == arbs_pkg::SEMR_OFS;
	wire hit_stat  = paddr == arbs_pkg::STAT_OFS;
	wire hit_any   = hit_ctrl | hit_presc | hit_semr | hit_stat;
	wire wr_ctrl   = access_ph & pwrite & hit_ctrl;
	wire wr_presc  = access_ph & pwrite & hit_presc;
	wire wr_semr   = access_ph & pwrite & hit_semr;

	// Mode fields.
	wire       async_base_clock_select       = semr_q[arbs_pkg::SEMR_ASYNC_BASE_CLOCK_SELECT_BIT];
	wire [3:0] acs        = semr_q[3:0];
	wire       async_mode = ~ctrl_q[arbs_pkg::CTRL_SYNC_BIT];
	wire       ext_on     = ctrl_q[arbs_pkg::CTRL_EXT_BIT];

	// The source field counts only in async mode with the external clock selected.
	wire       acs_on   = async_mode & ext_on;
	wire [3:0] code_eff = acs_on ? acs : arbs_pkg::CODE_NONE;

	// Average-rate lookup.
	logic                     avg_hit;  // Code drives the rate generator.
	logic                     avg_div8; // Its fixed bit divisor is eight.
	logic [arbs_pkg::ACC_W-1:0] avg_inc;  // Rate times divisor.
	logic [arbs_pkg::ACC_W-1:0] avg_mod;  // Calibration clock.

	// Each code ties a rate to the peripheral clock it was tuned for; the ratio, not the clock, is kept.
	always_comb begin
		avg_hit  = 1'b1;
		avg_div8 = 1'b0;
		avg_inc  = '0;
		avg_mod  = arbs_pkg::ACC_W'(arbs_pkg::PCLK_16M);
		case (code_eff)
			4'h1: begin
				avg_inc = arbs_pkg::ACC_W'(arbs_pkg::RATE_C1 * 16);
				avg_mod = arbs_pkg::ACC_W'(arbs_pkg::PCLK_10M667);
			end
			4'h2: begin
				avg_div8 = 1'b1;
				avg_inc  = arbs_pkg::ACC_W'(arbs_pkg::RATE_C2 * 8);
				avg_mod  = arbs_pkg::ACC_W'(arbs_pkg::PCLK_10M667);
			end
			4'h3: begin
				avg_div8 = 1'b1;
				avg_inc  = arbs_pkg::ACC_W'(arbs_pkg::RATE_C3 * 8);
			end
			4'h5: begin
				avg_inc = arbs_pkg::ACC_W'(arbs_pkg::RATE_C5 * 16);
			end
			4'h6: begin
				avg_inc = arbs_pkg::ACC_W'(arbs_pkg::RATE_C6 * 16);
			end
			4'h7: begin
				avg_div8 = 1'b1;
				avg_inc  = arbs_pkg::ACC_W'(arbs_pkg::RATE_C7 * 8);
				avg_mod  = arbs_pkg::ACC_W'(arbs_pkg::PCLK_24M);
			end
			4'h8: begin
				avg_inc = arbs_pkg::ACC_W'(arbs_pkg::RATE_C8 * 16);
				avg_mod = arbs_pkg::ACC_W'(arbs_pkg::PCLK_24M);
			end
			4'h9: begin
				avg_inc = arbs_pkg::ACC_W'(arbs_pkg::RATE_C9 * 16);
				avg_mod = arbs_pkg::ACC_W'(arbs_pkg::PCLK_24M);
			end
			4'ha: begin
				avg_div8 = 1'b1;
				avg_inc  = arbs_pkg::ACC_W'(arbs_pkg::RATE_CA * 8);
				avg_mod  = arbs_pkg::ACC_W'(arbs_pkg::PCLK_24M);
			end
			4'hb: begin
				avg_div8 = 1'b1;
				avg_inc  = arbs_pkg::ACC_W'(arbs_pkg::RATE_CB * 8);
				avg_mod  = arbs_pkg::ACC_W'(arbs_pkg::PCLK_24M);
			end
			4'hc: begin
				avg_inc = arbs_pkg::ACC_W'(arbs_pkg::RATE_CC * 16);
				avg_mod = arbs_pkg::ACC_W'(arbs_pkg::PCLK_32M);
			end
			// Code zero, the timer code and the reserved codes leave the generator idle.
			default: begin
				avg_hit = 1'b0;
			end
		endcase
	end

	// Source selection; reserved codes fall through to the same path as code zero.
	wire tmr_sel = code_eff == arbs_pkg::CODE_TMR;
	wire pin_sel = ext_on & ~avg_hit & ~tmr_sel;
	// Average codes fix the divisor; otherwise the base select bit counts in async mode only.
	wire div8_d  = avg_hit ? avg_div8 : (async_mode & async_base_clock_select);
	wire [4:0] per_bit = div8_sel ? arbs_pkg::BASE_PER_BIT_8 : arbs_pkg::BASE_PER_BIT_16;

	// External clock pin synchroniser and edge detect.
	logic sck_s1_q;
	logic sck_s2_q;
	logic sck_s3_q;
	wire  sck_rise = sck_s2_q & ~sck_s3_q;

	// Internal prescaler and source ticks.
	logic [7:0] presc_cnt_q;
	logic [3:0] code_q;
	logic       avg_tick;
	wire        presc_tick = presc_cnt_q == presc_q;
	wire        code_chg   = code_q != code_eff;
	wire        src_pulse  = avg_hit ? avg_tick : tmr_sel ? tmr_match : pin_sel ? sck_rise : presc_tick;
	logic [4:0] base_cnt_q;
	wire        last_base  = base_cnt_q >= per_bit - 5'h01;

	// Read mux for every mapped register.
	wire [7:0]  stat_v = {avg_hit, div8_d, tmr_sel, pin_sel, code_eff};
	wire [31:0] rd_mux = hit_ctrl  ? {29'h0, ctrl_q} :
	                     hit_presc ? {24'h0, presc_q} :
	                     hit_semr  ? {27'h0, semr_q} :
	                     hit_stat  ? {24'h0, stat_v} : 32'h0;

	// The generator restarts whenever the effective code changes.
	arbs_rate_gen #(
		.W(arbs_pkg::ACC_W)
	) u_rate_gen (
		.clk     (clk),
		.rst     (rst),
		.clear   (code_chg | ~avg_hit),
		.inc     (avg_inc),
		.modulus (avg_mod),
		.tick    (avg_tick)
	);

	// Zero wait states: read data is caught in setup so it can come from a flop.
	assign pready  = 1'b1;
	assign pslverr = access_ph & ~hit_any;
	assign prdata  = prdata_q;

	// Outputs straight from registers.
	assign smart_card_mode = ctrl_q[arbs_pkg::CTRL_SMART_BIT];
	assign sync_mode       = ctrl_q[arbs_pkg::CTRL_SYNC_BIT];
	assign ext_clk_sel     = ext_on;

	// Control register and read capture.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q   <= arbs_pkg::CTRL_RST;
			prdata_q <= 32'h0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= pwdata[2:0];
			end
			if (setup_ph) begin
				prdata_q <= rd_mux;
			end
		end
	end

	// Mode extension and prescaler registers; the status word ignores writes.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			semr_q  <= arbs_pkg::SEMR_RST;
			presc_q <= arbs_pkg::PRESC_RST;
		end else begin
			if (wr_semr) begin
				semr_q <= pwdata[4:0];
			end
			if (wr_presc) begin
				presc_q <= pwdata[7:0];
			end
		end
	end

	// Only the second and third stages are read, so a metastable first stage never reaches logic.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sck_s1_q <= 1'b0;
			sck_s2_q <= 1'b0;
			sck_s3_q <= 1'b0;
		end else begin
			sck_s1_q <= sck_in;
			sck_s2_q <= sck_s1_q;
			sck_s3_q <= sck_s2_q;
		end
	end

	// Prescaler runs freely; code tracker drives the generator restart.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			presc_cnt_q <= 8'h00;
			code_q      <= arbs_pkg::CODE_NONE;
		end else begin
			presc_cnt_q <= presc_tick ? 8'h00 : presc_cnt_q + 8'h01;
			code_q      <= code_eff;
		end
	end

	// Base tick and divisor select are registered one cycle after the source.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			base_tick <= 1'b0;
			div8_sel  <= 1'b0;
		end else begin
			base_tick <= src_pulse;
			div8_sel  <= div8_d;
		end
	end

	// Bit period counter: one bit tick per eight or sixteen base ticks.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			base_cnt_q <= 5'h00;
			bit_tick   <= 1'b0;
		end else begin
			bit_tick <= base_tick & last_base;
			if (base_tick) begin
				base_cnt_q <= last_base ? 5'h00 : base_cnt_q + 5'h01;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Smart card output follows the written bit.
	a_smart_card_out: assert property (wr_ctrl |=> smart_card_mode == $past(pwdata[0]))
		else $error("smart card mode does not follow write");

	// Plain async with base select low counts sixteen.
	a_div16_plain: assert property (!avg_hit && async_mode && !async_base_clock_select |=> !div8_sel)
		else $error("expected divide by sixteen");

	// Plain async with base select high counts eight.
	a_div8_plain: assert property (!avg_hit && async_mode && async_base_clock_select && $stable(semr_q) |=> div8_sel)
		else $error("expected divide by eight");

	// Synchronous mode ignores the base select bit.
	a_sync_ignores: assert property (!async_mode |=> !div8_sel)
		else $error("base select used outside async mode");

	// Generator is idle for code zero and reserved codes.
	a_code_idle: assert property (code_eff == 4'h0 || code_eff > arbs_pkg::CODE_LAST |-> !avg_hit && !tmr_sel)
		else $error("generator active for idle code");

	// Timer match becomes a base tick one cycle later.
	a_timer_source: assert property (tmr_sel && tmr_match |=> base_tick)
		else $error("timer match lost");

	// Divisors of the average codes.
	a_code_div8: assert property (code_eff inside {4'h2, 4'h3, 4'h7, 4'ha, 4'hb} |=> div8_sel)
		else $error("average code should divide by eight");
	a_code_div16: assert property (code_eff inside {4'h1, 4'h5, 4'h6, 4'h8, 4'h9, 4'hc} |=> !div8_sel)
		else $error("average code should divide by sixteen");

	// Code twelve uses the 32 MHz calibration.
	a_code_c_ratio: assert property (code_eff == 4'hc |-> avg_mod == arbs_pkg::ACC_W'(arbs_pkg::PCLK_32M))
		else $error("code twelve ratio wrong");

	// Base select changes do not move the divisor under an average code.
	a_async_base_clock_select_ignored: assert property (avg_hit && $stable(code_eff) ##1 avg_hit && $stable(code_eff) |=> $stable(div8_sel))
		else $error("base select disturbed average divisor");

	// Outside async external mode the source field has no effect.
	a_field_gated: assert property (!acs_on |-> code_eff == 4'h0 && !avg_hit)
		else $error("source field active while gated");

	// Only a control write moves the smart card output.
	a_smart_card_hold: assert property (!wr_ctrl |=> $stable(smart_card_mode))
		else $error("smart card mode changed without a write");

	// Code zero keeps the divisor of the base select bit.
	a_zero_uses_async_base_clock_select: assert property (acs_on && acs == arbs_pkg::CODE_NONE |=> div8_sel == $past(async_base_clock_select))
		else $error("code zero ignored base select");

	// With the external clock and code zero, each pin rise becomes a base tick.
	a_pin_source: assert property (pin_sel && sck_rise |=> base_tick)
		else $error("serial clock rise lost");

	// Under the timer code no other source may make a base tick.
	a_timer_only: assert property (tmr_sel && !tmr_match |=> !base_tick)
		else $error("base tick without timer match");

	// Under an average code the generator alone makes base ticks.
	a_avg_source: assert property (avg_hit |=> base_tick == $past(avg_tick))
		else $error("base tick not from rate generator");

	// Reserved codes keep the divisor of the base select bit, as code zero does.
	a_reserved_async_base_clock_select: assert property (acs_on && acs > arbs_pkg::CODE_LAST |=> div8_sel == $past(async_base_clock_select))
		else $error("reserved code ignored base select");

	// A bit period spans exactly the chosen number of base ticks.
	sequence s_last_base;
		base_tick && base_cnt_q == per_bit - 5'h01;
	endsequence
	a_bit_period: assert property (s_last_base |=> bit_tick ##0 base_cnt_q == 5'h00)
		else $error("bit tick misplaced");

endmodule : arbs_baud_select

/* File: dv/arbs_line_partner.sv */
// Far-side model: the external serial clock pin and the timer compare-match pulse.
// Assumes the bench clock; both pins change just after a rising edge.
`timescale 1ns/1ps
module arbs_line_partner #(
	parameter int SCK_HALF = 2,
	parameter int TMR_PER  = 7
) (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst,
	// Enables from the bench.
	input  wire logic sck_en,
	input  wire logic tmr_en,
	// Pins toward the block.
	output logic      sck_in,
	output logic      tmr_match
);
	int sck_cnt; // Cycles since the last serial clock edge.
	int tmr_cnt; // Cycles since the last match pulse.

	// The serial clock stands low while disabled, as a remote sender idles between frames.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sck_cnt <= 0;
			sck_in  <= 1'b0;
		end else if (!sck_en) begin
			sck_cnt <= 0;
			sck_in  <= 1'b0;
		end else begin
			sck_cnt <= (sck_cnt == SCK_HALF - 1) ? 0 : sck_cnt + 1;
			if (sck_cnt == SCK_HALF - 1) begin
				sck_in <= ~sck_in;
			end
		end
	end

	// The timer match is a one-cycle pulse every TMR_PER cycles, never wider.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tmr_cnt   <= 0;
			tmr_match <= 1'b0;
		end else begin
			tmr_cnt   <= (tmr_cnt == TMR_PER - 1) ? 0 : tmr_cnt + 1;
			tmr_match <= tmr_en && (tmr_cnt == TMR_PER - 1);
		end
	end
endmodule : arbs_line_partner

/* File: dv/arbs_baud_select_bench.sv */
// Self-checking bench for the baud select block and its registers.
// Assumes the line partner drives the timer match and the serial clock pin.
`timescale 1ns/1ps
module arbs_baud_select_bench;
	localparam int TPER = 7; // Timer match period in clocks.
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [23:0] paddr = 24'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        tmr_match;
	logic        sck_in;
	logic        smart_card_mode;
	logic        sync_mode;
	logic        ext_clk_sel;
	logic        div8_sel;
	logic        base_tick;
	logic        bit_tick;
	logic        sck_en = 1'b0;
	logic        tmr_en = 1'b0;
	logic [31:0] rd;
	logic        er;
	int          errors = 0;
	int          compares = 0;
	int          n;

	// A 200 MHz clock.
	always #2.5 clk = ~clk;

	arbs_baud_select u_arbs_baud_select (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tmr_match(tmr_match), .sck_in(sck_in), .smart_card_mode(smart_card_mode),
		.sync_mode(sync_mode), .ext_clk_sel(ext_clk_sel), .div8_sel(div8_sel), .base_tick(base_tick),
		.bit_tick(bit_tick));
	arbs_line_partner #(.SCK_HALF(2), .TMR_PER(TPER)) u_arbs_line_partner (.clk(clk), .rst(rst),
		.sck_en(sck_en), .tmr_en(tmr_en), .sck_in(sck_in), .tmr_match(tmr_match));

	// Counts a comparison and reports a mismatch at once.
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask : chk

	// One APB transfer; the request holds until pready is seen high at an edge.
	task apb(input logic w, input logic [23:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		// A transfer that never completes counts as a mismatch.
		if (pready !== 1'b1) begin
			errors++;
			$display("unexpected pready: expected 1, seen %b", pready);
		end
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Clocks from one base tick to the next.
	task gap(output int g);
		int k;
		k = 0;
		@(negedge clk);
		while (base_tick !== 1'b1 && k < 500) begin
			@(negedge clk);
			k++;
		end
		g = 0;
		do begin
			@(negedge clk);
			g++;
		end while (base_tick !== 1'b1 && g < 500);
	endtask : gap

	// Base ticks in one whole bit period; the partial period and the two whole periods after a change are skipped.
	task per_bit(output int b);
		int k;
		k = 0;
		repeat (2) begin
			@(negedge clk);
			while (bit_tick !== 1'b1 && k < 5000) begin
				@(negedge clk);
				k++;
			end
			b = 0;
			do begin
				b += int'(base_tick);
				@(negedge clk);
				k++;
			end while (bit_tick !== 1'b1 && k < 5000);
		end
	endtask : per_bit

	// Reset values, an unmapped read and the read-only status place.
	task t_reset();
		apb(1'b0, arbs_pkg::CTRL_OFS, 32'h0);
		chk("ctrl", 32'h0, rd);
		apb(1'b0, arbs_pkg::SEMR_OFS, 32'h0);
		chk("semr", 32'h3, rd);
		apb(1'b0, 24'hfff610, 32'h0);
		chk("unmapped err", 32'h1, 32'(er));
		apb(1'b1, arbs_pkg::STAT_OFS, 32'hff);
		apb(1'b0, arbs_pkg::STAT_OFS, 32'h0);
		chk("status code", 32'h0, 32'(rd[3:0]));
		gap(n);
		chk("reset gap", 32'd16, 32'(n));
	endtask : t_reset

	// Smart card select follows the control bit both ways.
	task t_smart();
		apb(1'b1, arbs_pkg::CTRL_OFS, 32'h1);
		@(negedge clk);
		chk("smart on", 32'h1, 32'(smart_card_mode));
		apb(1'b1, arbs_pkg::CTRL_OFS, 32'h0);
		@(negedge clk);
		chk("smart off", 32'h0, 32'(smart_card_mode));
	endtask : t_smart

	// External clock, codes 0000, 0100 and the reserved ones.
	task t_base();
		sck_en <= 1'b1;
		apb(1'b1, arbs_pkg::CTRL_OFS, 32'h4);
		apb(1'b1, arbs_pkg::SEMR_OFS, 32'h00);
		per_bit(n);
		chk("div16 bits", 32'd16, 32'(n));
		apb(1'b1, arbs_pkg::SEMR_OFS, 32'h10);
		per_bit(n);
		chk("div8 bits", 32'd8, 32'(n));
		for (int c = 13; c < 16; c++) begin
			apb(1'b1, arbs_pkg::SEMR_OFS, 32'h10 | 32'(c));
			per_bit(n);
			chk("reserved bits", 32'd8, 32'(n));
			gap(n);
			chk("reserved gap", 32'd4, 32'(n));
		end
		sck_en <= 1'b0;
		tmr_en <= 1'b1;
		apb(1'b1, arbs_pkg::SEMR_OFS, 32'h04);
		gap(n);
		chk("timer gap", 32'(TPER), 32'(n));
		per_bit(n);
		chk("timer bits", 32'd16, 32'(n));
		apb(1'b1, arbs_pkg::SEMR_OFS, 32'h14);
		per_bit(n);
		chk("timer div8", 32'd8, 32'(n));
		tmr_en <= 1'b0;
	endtask : t_base

	// Every average code: divisor set on its own and base tick rate to its table figure.
	task t_avg();
		logic d8;
		real  r;
		real  p;
		real  e;
		for (int c = 1; c < 13; c++) begin
			if (c != 4) begin
				case (c)
					1: begin d8 = 1'b0; r = arbs_pkg::RATE_C1; p = arbs_pkg::PCLK_10M667; end
					2: begin d8 = 1'b1; r = arbs_pkg::RATE_C2; p = arbs_pkg::PCLK_10M667; end
					3: begin d8 = 1'b1; r = arbs_pkg::RATE_C3; p = arbs_pkg::PCLK_16M; end
					5: begin d8 = 1'b0; r = arbs_pkg::RATE_C5; p = arbs_pkg::PCLK_16M; end
					6: begin d8 = 1'b0; r = arbs_pkg::RATE_C6; p = arbs_pkg::PCLK_16M; end
					7: begin d8 = 1'b1; r = arbs_pkg::RATE_C7; p = arbs_pkg::PCLK_24M; end
					8: begin d8 = 1'b0; r = arbs_pkg::RATE_C8; p = arbs_pkg::PCLK_24M; end
					9: begin d8 = 1'b0; r = arbs_pkg::RATE_C9; p = arbs_pkg::PCLK_24M; end
					10: begin d8 = 1'b1; r = arbs_pkg::RATE_CA; p = arbs_pkg::PCLK_24M; end
					11: begin d8 = 1'b1; r = arbs_pkg::RATE_CB; p = arbs_pkg::PCLK_24M; end
					default: begin d8 = 1'b0; r = arbs_pkg::RATE_CC; p = arbs_pkg::PCLK_32M; end
				endcase
				// The base select bit is set against the code to show that it is disregarded.
				apb(1'b1, arbs_pkg::SEMR_OFS, (d8 ? 32'h0 : 32'h10) | 32'(c));
				// The divisor select is registered one cycle after the write lands.
				repeat (2) @(negedge clk);
				chk("avg div8", 32'(d8), 32'(div8_sel));
				n = 0;
				repeat (4000) begin
					@(negedge clk);
					n += int'(base_tick);
				end
				e = 4000.0 * r * (d8 ? 8.0 : 16.0) / p;
				compares++;
				if (n < e - 2.0 || n > e + 2.0) begin
					errors++;
					$display("unexpected avg ticks: expected %0d, seen %0d", $rtoi(e), n);
				end
			end
		end
	endtask : t_avg

	// Source field gated off without external clock, and base select ignored in sync mode.
	task t_gate();
		apb(1'b1, arbs_pkg::CTRL_OFS, 32'h0);
		apb(1'b1, arbs_pkg::PRESC_OFS, 32'h3);
		apb(1'b1, arbs_pkg::SEMR_OFS, 32'h11);
		gap(n);
		chk("no ext gap", 32'd4, 32'(n));
		chk("no ext div8", 32'h1, 32'(div8_sel));
		apb(1'b1, arbs_pkg::CTRL_OFS, 32'h6);
		repeat (2) @(negedge clk);
		chk("sync div8", 32'h0, 32'(div8_sel));
		chk("sync mode", 32'h1, 32'(sync_mode));
		chk("ext select", 32'h1, 32'(ext_clk_sel));
		apb(1'b0, arbs_pkg::STAT_OFS, 32'h0);
		chk("sync code", 32'h0, 32'(rd[3:0]));
	endtask : t_gate

	// Prints the counts and the verdict, then ends the run.
	task test_done();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done

	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_smart();
		t_base();
		t_avg();
		t_gate();
		test_done();
	end

	// A hang is cut short well beyond the expected run of about 46000 clocks.
	initial begin
		#450000;
		errors++;
		test_done();
	end
endmodule : arbs_baud_select_bench
